// ==== common/fsr_defines.vh ====
// constants for the serial flash command interpreter
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// opcodes seen on the serial input
`define FSR_OP_SFDP      8'h5A
`define FSR_OP_UID       8'h4B
`define FSR_OP_IDENT     8'h9F
`define FSR_OP_SR_ERASE  8'h44
`define FSR_OP_SR_PROG   8'h42
`define FSR_OP_SR_READ   8'h48
`define FSR_OP_RST_EN    8'h66
`define FSR_OP_RST       8'h99
`define FSR_OP_UNLOCK    8'h06
`define FSR_OP_WAKE      8'hAB
`define FSR_OP_NONE      8'h00

// security region geometry
`define FSR_REGION_BYTES 1024
`define FSR_REGIONS      3
`define FSR_PAGE_BYTES   256

// timing in microseconds and MHz, sized so cycle products stay 24 bits
`define FSR_CLK_MHZ       24'h14
`define FSR_ERASE_TIME_US 24'h3E8
`define FSR_PROG_TIME_US  24'h1F4
`define FSR_RST_TIME_US   24'h1E

// apb byte offsets
`define FSR_OFF_STATUS 8'h00
`define FSR_OFF_CTRL   8'h04
`define FSR_OFF_LOCK   8'h08

// status word bit positions
`define FSR_ST_WIP  0
`define FSR_ST_WEL  1
`define FSR_ST_LB1  11
`define FSR_ST_S22  22
`define FSR_ST_DPD  24
`define FSR_ST_RSTB 25

// control word fields
`define FSR_CT_DPD_BIT 16

// reset values
`define FSR_S22_RST   1'b1
`define FSR_PARAM_RST 8'h00
`define FSR_WRAP_RST  3'h1
`define FSR_ERASED    8'hFF

`endif

// ==== dv/fsr_flash_cmd_monitor.sv ====
// port-level assertions for the flash command interpreter
`timescale 1ns/1ns
module fsr_flash_cmd_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        spi_sclk,
    input wire        spi_cs_n,
    input wire        spi_so,
    input wire        spi_so_oe
);
    wire       st_rd;
    reg  [2:0] lock_q;
    reg        acc_q;

    assign st_rd = psel && penable && !pwrite && paddr == 8'h00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // lock bits once seen, and whether any access has completed
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= 3'h0;
            acc_q  <= 1'b0;
        end
        else
        begin
            if (st_rd)
                lock_q <= lock_q | prdata[13:11];
            acc_q <= acc_q | (psel && penable);
        end
    end

    property p_so_fall; spi_so_oe && $changed(spi_so) |-> !spi_sclk; endproperty
    property p_oe_go; $rose(spi_so_oe) |-> !spi_cs_n && !spi_sclk; endproperty
    property p_oe_end; $rose(spi_cs_n) |-> ##[1:5] !spi_so_oe; endproperty
    property p_s22; st_rd |-> prdata[22] && prdata[31:26] == 6'h00; endproperty
    property p_first; st_rd && !acc_q |-> prdata == 32'h0040_0000; endproperty
    property p_busy; st_rd && prdata[0] |-> !prdata[1]; endproperty
    property p_rec; st_rd && prdata[25] |-> prdata[1:0] == 2'b01; endproperty
    property p_lock; st_rd |-> (prdata[13:11] & lock_q) == lock_q; endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output moved with clock high");
    a_oe_go: assert property (p_oe_go)
        else $error("output enabled off a falling edge");
    a_oe_end: assert property (p_oe_end)
        else $error("output still driven after deselect");
    a_s22: assert property (p_s22)
        else $error("status top bits wrong");
    a_first: assert property (p_first)
        else $error("status after reset wrong");
    a_busy: assert property (p_busy)
        else $error("latch set while busy");
    a_rec: assert property (p_rec)
        else $error("latch set or busy clear in recovery");
    a_lock: assert property (p_lock)
        else $error("lock bit cleared");
    c_out: cover property ($rose(spi_so_oe));
    c_busy: cover property (st_rd && prdata[0]);
    c_rec: cover property (st_rd && prdata[25]);
endmodule // fsr_flash_cmd_monitor

bind fsr_flash_cmd fsr_flash_cmd_monitor i_fsr_flash_cmd_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe));

// ==== dv/fsr_host_model.sv ====
// host serial controller model driving the flash pins in mode 0
`timescale 1ns/1ns
module fsr_host_model #(
    parameter PWRUP_NS = 100000 // select delay after supply is up
)(
    input  wire  pclk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_si,
    input  wire  spi_so,
    input  wire  spi_so_oe,
    output logic oe_seen
);
    logic last_b;

    // pins idle at time zero; clock stands still outside frames
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
        last_b   = 1'b0;
        oe_seen  = 1'b0;
    end

    // open a frame, never before the power-up select delay
    task sel();
        while ($time < PWRUP_NS)
            @(posedge pclk);
        @(posedge pclk);
        spi_cs_n <= 1'b0;
        oe_seen  <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // close right on a byte boundary, then stay deselected a while
    task desel();
        repeat (2) @(posedge pclk);
        spi_cs_n <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask

    // one byte msb first; a released line reads as its inverse
    task xb(input [7:0] tx, output [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            spi_si <= tx[i];
            repeat (4) @(posedge pclk);
            spi_sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            last_b = spi_so_oe ? spi_so : ~last_b;
            rx[i] = last_b;
            if (spi_so_oe)
                oe_seen <= 1'b1;
            spi_sclk <= 1'b0;
        end
    endtask
endmodule // fsr_host_model

// ==== dv/tb_top.sv ====
// self-checking bench for the flash command interpreter
`timescale 1ns/1ns
`include "fsr_defines.vh"
module tb_top;
    localparam [127:0] UIDV  = 128'h00112233445566778899AABBCCDDEEFF;
    localparam [7:0]   MAKER = 8'hC3; // arbitrary value
    localparam [7:0]   MTYPE = 8'h21; // arbitrary value
    localparam [7:0]   MCAP  = 8'h15; // arbitrary value
    localparam [7:0]   ST    = `FSR_OFF_STATUS;
    localparam [7:0]   CT    = `FSR_OFF_CTRL;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] rv;
    logic        rerr;
    logic [7:0]  rb [16];
    logic [7:0]  wq [$];
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         spi_sclk;
    wire         spi_cs_n;
    wire         spi_si;
    wire         spi_so;
    wire         spi_so_oe;
    wire         host_oe;
    int          errors;
    int          n_tests;

    // short cycle counts keep the run brief
    fsr_flash_cmd #(.ERASE_CYC(24'h0007D0), .PROG_CYC(24'h0000C8),
        .UID(UIDV), .MAKER_ID(MAKER), .TYPE_ID(MTYPE), .CAP_ID(MCAP))
    i_fsr_flash_cmd (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe));
    fsr_host_model i_fsr_host_model (.pclk(pclk), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .oe_seen(host_oe));

    // 20 MHz system clock
    always #25 pclk = ~pclk;

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // apb transfer held until pready is sampled high
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) // only the watchdog ends a stall
            @(posedge pclk);
        rv = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // one frame: opcode, address, dummies, queued data, then reads
    task frm(input [7:0] op, input [23:0] a, input int na, input int nd,
             input int nr);
        logic [7:0] x;
        i_fsr_host_model.sel();
        i_fsr_host_model.xb(op, x);
        for (int i = 0; i < na; i++)
            i_fsr_host_model.xb(a[23 - 8 * i -: 8], x);
        for (int i = 0; i < nd; i++)
            i_fsr_host_model.xb(8'h00, x);
        foreach (wq[i])
            i_fsr_host_model.xb(wq[i], x);
        wq.delete();
        for (int i = 0; i < nr; i++)
            i_fsr_host_model.xb(8'hFF, rb[i]);
        i_fsr_host_model.desel();
    endtask

    task op1(input [7:0] op);
        frm(op, 24'h0, 0, 0, 0);
    endtask

    // poll a status bit until clear; a long wait is a mismatch
    task waitc(input int b);
        int n;
        n = 0;
        rd(ST);
        while (rv[b] !== 1'b0 && n < 1000)
        begin
            rd(ST);
            n++;
        end
        chk("bit clears", rv[b], 1'b0);
    endtask

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // cuts a hang short well beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge pclk);
        errors++;
        report_and_stop();
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ST);
        chk("status", rv, 32'h0040_0000);
        rd(CT);
        chk("ctrl", rv, 32'h0000_0100);
        rd(8'h0C);
        chk("pslverr", rerr, 1'b1);
        $display("done: defaults");
        frm(`FSR_OP_IDENT, 24'h0, 0, 0, 3);
        chk("maker", rb[0], MAKER);
        chk("type", rb[1], MTYPE);
        chk("capacity", rb[2], MCAP);
        frm(`FSR_OP_UID, 24'h0, 0, 4, 16);
        for (int i = 0; i < 16; i++)
            chk("uid", rb[i], UIDV[127 - 8 * i -: 8]);
        frm(`FSR_OP_SFDP, 24'h000002, 3, 1, 1);
        chk("table", rb[0], 8'h44);
        $display("done: identification");
        frm(`FSR_OP_SR_ERASE, 24'h001000, 3, 0, 0);
        rd(ST);
        chk("no latch", rv[1:0], 2'b00);
        op1(`FSR_OP_UNLOCK);
        wq = '{8'hA5, 8'h3C};
        frm(`FSR_OP_SR_PROG, 24'h0013FE, 3, 0, 0);
        rd(ST);
        chk("prog busy", rv[1:0], 2'b01);
        waitc(0);
        frm(`FSR_OP_SR_READ, 24'h0013FE, 3, 1, 3);
        chk("byte 3FE", rb[0], 8'hA5);
        chk("byte 3FF", rb[1], 8'h3C);
        chk("wrap", rb[2], 8'hFF);
        op1(`FSR_OP_UNLOCK);
        frm(`FSR_OP_SR_ERASE, 24'h001000, 3, 1, 0);
        rd(ST);
        chk("long erase", rv[0], 1'b0);
        op1(`FSR_OP_UNLOCK);
        frm(`FSR_OP_SR_ERASE, 24'h001000, 3, 0, 0);
        rd(ST);
        chk("erase busy", rv[1:0], 2'b01);
        frm(`FSR_OP_IDENT, 24'h0, 0, 0, 3);
        chk("id busy", host_oe, 1'b0);
        rd(ST);
        chk("still busy", rv[0], 1'b1);
        waitc(0);
        frm(`FSR_OP_SR_READ, 24'h0013FE, 3, 1, 2);
        chk("erased", {rb[0], rb[1]}, 16'hFFFF);
        $display("done: regions");
        apb(1'b1, `FSR_OFF_LOCK, 32'h0000_0801);
        rd(ST);
        chk("lock", rv[13:11], 3'b001);
        op1(`FSR_OP_UNLOCK);
        wq = '{8'h00};
        frm(`FSR_OP_SR_PROG, 24'h001000, 3, 0, 0);
        rd(ST);
        chk("locked prog", rv[0], 1'b0);
        $display("done: locks");
        apb(1'b1, CT, 32'h0001_0000);
        rd(ST);
        chk("powered down", rv[24], 1'b1);
        frm(`FSR_OP_UID, 24'h0, 0, 4, 1);
        chk("uid refused", host_oe, 1'b0);
        op1(`FSR_OP_WAKE);
        rd(ST);
        chk("awake", rv[24], 1'b0);
        $display("done: power-down");
        apb(1'b1, CT, 32'h0000_005A);
        op1(`FSR_OP_UNLOCK);
        rd(ST);
        chk("idle", rv[1:0], 2'b10);
        op1(`FSR_OP_RST_EN);
        frm(`FSR_OP_IDENT, 24'h0, 0, 0, 3);
        op1(`FSR_OP_RST);
        rd(ST);
        chk("no reset", rv[25], 1'b0);
        rd(CT);
        chk("ctrl kept", rv, 32'h0000_005A);
        op1(`FSR_OP_RST_EN);
        op1(`FSR_OP_RST);
        rd(ST);
        chk("recovery", rv[25], 1'b1);
        frm(`FSR_OP_IDENT, 24'h0, 0, 0, 3);
        chk("id refused", host_oe, 1'b0);
        waitc(25);
        rd(ST);
        chk("status", rv, 32'h0040_0800);
        rd(CT);
        chk("ctrl", rv, 32'h0000_0100);
        $display("done: reset");
        report_and_stop();
    end
endmodule // tb_top

// ==== rtl/fsr_flash_cmd.v ====
// serial flash id, security region and software reset command interpreter
//
// Behaviour
// - discoverable-parameter read takes 24-bit address, low byte starts in table
// - unique ID read: opcode, four dummy bytes, then 128-bit fixed value
// - identification read returns maker byte, memory type byte, capacity byte
// - identification read during erase or program is not decoded
// - identification shifted on falling clock; select high ends output
// - three 1024-byte regions chosen by address bits 15..12
// - region erase needs write latch flag set beforehand
// - region erase frame must end exactly on a byte boundary
// - region erase runs timed cycle, busy flag high, latch flag cleared
// - a set region lock bit blocks erase of that region
// - region program needs latch flag, opcode, address, 1..256 data bytes
// - region program runs timed cycle on select rise, latch cleared
// - a set region lock bit blocks program of that region
// - region read: opcode, address, one dummy byte, data on falling edges
// - region read address increments and wraps inside the region
// - software reset aborts work and restores volatile defaults
// - reset enable frame must be followed directly by reset frame
// - during reset recovery every command is rejected
// - array erased to all ones, status zero except bit twenty-two
// - in deep power-down only wake and software reset are obeyed
`timescale 1ns/1ns
`include "fsr_defines.vh"

module fsr_flash_cmd #(
    parameter [23:0]  ERASE_CYC = `FSR_ERASE_TIME_US * `FSR_CLK_MHZ,
    parameter [23:0]  PROG_CYC  = `FSR_PROG_TIME_US * `FSR_CLK_MHZ,
    parameter [127:0] UID       = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
    parameter [7:0]   MAKER_ID  = 8'hA5, // arbitrary value
    parameter [7:0]   TYPE_ID   = 8'h40, // arbitrary value
    parameter [7:0]   CAP_ID    = 8'h16  // arbitrary value
)(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        spi_si,
    output reg         spi_so,
    output reg         spi_so_oe
);

    localparam [23:0] RST_CYC = `FSR_RST_TIME_US * `FSR_CLK_MHZ;
    localparam        DEPTH   = `FSR_REGIONS * `FSR_REGION_BYTES;
    // one-hot internal operation states
    localparam [3:0]  ST_IDLE  = 4'h1;
    localparam [3:0]  ST_ERASE = 4'h2;
    localparam [3:0]  ST_PROG  = 4'h4;
    localparam [3:0]  ST_RST   = 4'h8;

    // region number 1..3 from an address, 0 when not a region
    function [1:0] region_of;
        input [23:0] a;
        begin
            if (a[23:16] == 8'h00 && a[11:10] == 2'b00
                && a[15:12] != 4'h0 && a[15:12] <= 4'h3)
                region_of = a[13:12];
            else
                region_of = 2'd0;
        end
    endfunction

    // flat memory index of a region byte
    function [11:0] mem_idx;
        input [1:0] r;
        input [9:0] b;
        begin
            mem_idx = {r - 2'd1, b};
        end
    endfunction

    // discoverable-parameter table, unprogrammed entries read as ones
    function [7:0] table_byte;
        input [7:0] a;
        begin
            case (a)
                8'h00:   table_byte = 8'h53;
                8'h01:   table_byte = 8'h46;
                8'h02:   table_byte = 8'h44;
                8'h03:   table_byte = 8'h50;
                default: table_byte = 8'hFF;
            endcase
        end
    endfunction

    reg  [2:0]   sclk_sy_q, cs_sy_q, bit_q, lock_q, wrap_setting_bits_q;
    reg  [1:0]   si_sy_q, tgt_q;
    reg  [7:0]   sh_q, op_q, out_sh_q, read_param_bits_q, acc_op, next_out;
    reg  [9:0]   idx_q;
    reg  [23:0]  addr_q, timer_q;
    reg  [3:0]   st_q;
    reg          out_act_q, pg_seen_q, write_latch_flag_q, s22_q, dpd_q;
    reg          rst_en_q, load_out;
    reg  [7:0]   mem_q [0:DEPTH-1];
    integer      i;
    // first stage flops feed only the second stage
    wire         rise  = sclk_sy_q[1] & ~sclk_sy_q[2];
    wire         fall  = ~sclk_sy_q[1] & sclk_sy_q[2];
    wire         sel   = ~cs_sy_q[1];
    wire         cs_up = cs_sy_q[1] & ~cs_sy_q[2];
    wire [7:0]   nb    = {sh_q[6:0], si_sy_q[1]};
    wire         done  = (bit_q == 3'd7);
    wire         cycle_active_flag = ~st_q[0];
    wire         rst_busy = st_q[3];
    wire [1:0]   reg_now = region_of(addr_q);
    wire [2:0]   lock_hit = lock_q >> (reg_now - 2'd1);
    wire [3:0]   uid_k = idx_q[3:0] - 4'd4;
    wire [127:0] uid_sh = UID << {uid_k, 3'b000};
    wire [11:0]  rd_idx = mem_idx(reg_now, addr_q[9:0]);
    wire [7:0]   cur_op = (idx_q == 10'd0) ? acc_op : op_q;
    wire         apb_wr = psel & penable & pwrite;
    wire [31:0]  status_w;

    assign pready = 1'b1;
    assign status_w = ({31'd0, cycle_active_flag} << `FSR_ST_WIP)
                    | ({31'd0, write_latch_flag_q} << `FSR_ST_WEL)
                    | ({29'd0, lock_q} << `FSR_ST_LB1)
                    | ({31'd0, s22_q} << `FSR_ST_S22)
                    | ({31'd0, dpd_q} << `FSR_ST_DPD)
                    | ({31'd0, rst_busy} << `FSR_ST_RSTB);
    // opcode gate: busy, recovery and power-down filter what is decoded
    always @*
    begin
        acc_op = nb;
        if (rst_busy)
            acc_op = `FSR_OP_NONE;
        else if (cycle_active_flag && nb != `FSR_OP_RST_EN
                 && nb != `FSR_OP_RST)
            acc_op = `FSR_OP_NONE; // only the reset pair passes a cycle
        else if (dpd_q && nb != `FSR_OP_WAKE && nb != `FSR_OP_RST_EN
                 && nb != `FSR_OP_RST)
            acc_op = `FSR_OP_NONE;
    end
    // next byte to present on the serial output, decided per input byte
    always @*
    begin
        load_out = (idx_q >= 10'd4);
        next_out = `FSR_ERASED;
        case (cur_op)
            `FSR_OP_IDENT:
            begin
                load_out = 1'b1;
                case (idx_q)
                    10'd0:   next_out = MAKER_ID;
                    10'd1:   next_out = TYPE_ID;
                    10'd2:   next_out = CAP_ID;
                    default: next_out = 8'h00;
                endcase
            end
            `FSR_OP_SFDP:
                if (addr_q[23:8] == 16'h0000)
                    next_out = table_byte(addr_q[7:0]);
            `FSR_OP_UID:
                if (idx_q <= 10'd19)
                    next_out = uid_sh[127:120];
            `FSR_OP_SR_READ:
                if (reg_now != 2'd0)
                    next_out = mem_q[rd_idx];
            default:
                load_out = 1'b0;
        endcase
    end

    // pin synchronisers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_sy_q <= 3'h0;
            cs_sy_q   <= 3'h7;
            si_sy_q   <= 2'h0;
        end
        else
        begin
            sclk_sy_q <= {sclk_sy_q[1:0], spi_sclk};
            cs_sy_q   <= {cs_sy_q[1:0], spi_cs_n};
            si_sy_q   <= {si_sy_q[0], spi_si};
        end
    end

    // apb read path, captured in the setup cycle for a zero-wait access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            pslverr <= 1'b0;
            case (paddr)
                `FSR_OFF_STATUS: prdata <= status_w;
                `FSR_OFF_CTRL:   prdata <= {21'd0, wrap_setting_bits_q,
                                            read_param_bits_q};
                `FSR_OFF_LOCK:   prdata <= {29'd0, lock_q};
                default:
                begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // serial frame, memory and internal operation state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q                <= 8'h0;
            bit_q               <= 3'd0;
            idx_q               <= 10'd0;
            op_q                <= `FSR_OP_NONE;
            addr_q              <= 24'h0;
            out_sh_q            <= `FSR_ERASED;
            out_act_q           <= 1'b0;
            pg_seen_q           <= 1'b0;
            st_q                <= ST_IDLE;
            timer_q             <= 24'h0;
            tgt_q               <= 2'd0;
            write_latch_flag_q  <= 1'b0;
            lock_q              <= 3'h0;
            s22_q               <= `FSR_S22_RST;
            dpd_q               <= 1'b0;
            rst_en_q            <= 1'b0;
            read_param_bits_q   <= `FSR_PARAM_RST;
            wrap_setting_bits_q <= `FSR_WRAP_RST;
            spi_so              <= 1'b0;
            spi_so_oe           <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= `FSR_ERASED;
        end
        else
        begin
            // software side: volatile settings, one-time locks, power-down
            if (apb_wr && paddr == `FSR_OFF_CTRL)
            begin
                read_param_bits_q   <= pwdata[7:0];
                wrap_setting_bits_q <= pwdata[10:8];
                if (pwdata[`FSR_CT_DPD_BIT] && !cycle_active_flag)
                    dpd_q <= 1'b1;
            end
            if (apb_wr && paddr == `FSR_OFF_LOCK)
                lock_q <= lock_q | pwdata[2:0]; // set only, never cleared
            // self-timed cycle countdown
            if (cycle_active_flag)
            begin
                timer_q <= timer_q - 24'd1;
                if (timer_q <= 24'd1)
                begin
                    st_q <= ST_IDLE;
                    if (st_q[1])
                        for (i = 0; i < `FSR_REGION_BYTES; i = i + 1)
                            mem_q[mem_idx(tgt_q, i[9:0])] <= `FSR_ERASED;
                end
            end
            if (!sel)
            begin
                // deselected: output released, next frame starts clean
                bit_q     <= 3'd0;
                idx_q     <= 10'd0;
                out_act_q <= 1'b0;
                spi_so_oe <= 1'b0;
                pg_seen_q <= 1'b0;
            end
            else if (rise)
            begin
                sh_q  <= nb;
                bit_q <= bit_q + 3'd1;
                if (done)
                begin
                    if (idx_q != 10'h3FF)
                        idx_q <= idx_q + 10'd1;
                    if (idx_q == 10'd0)
                        op_q <= acc_op;
                    if (idx_q >= 10'd1 && idx_q <= 10'd3)
                        addr_q <= {addr_q[15:0], nb};
                    if (load_out)
                    begin
                        out_sh_q  <= next_out;
                        out_act_q <= 1'b1;
                        if (idx_q >= 10'd4)
                            addr_q[9:0] <= (cur_op == `FSR_OP_SFDP)
                                ? {2'b00, addr_q[7:0] + 8'd1}
                                : addr_q[9:0] + 10'd1;
                    end
                    // program bytes clear bits in place, page address wraps
                    if (cur_op == `FSR_OP_SR_PROG && idx_q >= 10'd4
                        && write_latch_flag_q && reg_now != 2'd0
                        && !lock_hit[0])
                    begin
                        mem_q[rd_idx]  <= mem_q[rd_idx] & nb;
                        addr_q[7:0]    <= addr_q[7:0] + 8'd1;
                        pg_seen_q      <= 1'b1;
                    end
                end
            end
            else if (fall && out_act_q)
            begin
                spi_so    <= out_sh_q[7];
                spi_so_oe <= 1'b1;
                out_sh_q  <= {out_sh_q[6:0], 1'b1};
            end
            // commands that act when select rises
            if (cs_up && idx_q != 10'd0)
            begin
                rst_en_q <= (op_q == `FSR_OP_RST_EN);
                case (op_q)
                    `FSR_OP_UNLOCK:
                        if (idx_q == 10'd1 && bit_q == 3'd0)
                            write_latch_flag_q <= 1'b1;
                    `FSR_OP_WAKE:
                        dpd_q <= 1'b0;
                    `FSR_OP_SR_ERASE:
                        if (idx_q == 10'd4 && bit_q == 3'd0
                            && write_latch_flag_q
                            && reg_now != 2'd0 && !lock_hit[0])
                        begin
                            st_q               <= ST_ERASE;
                            timer_q            <= ERASE_CYC;
                            tgt_q              <= reg_now;
                            write_latch_flag_q <= 1'b0;
                        end
                    `FSR_OP_SR_PROG:
                        if (pg_seen_q)
                        begin
                            st_q               <= ST_PROG;
                            timer_q            <= PROG_CYC;
                            write_latch_flag_q <= 1'b0;
                        end
                    `FSR_OP_RST:
                        if (rst_en_q)
                        begin
                            // abort wins over any running cycle
                            st_q                <= ST_RST;
                            timer_q             <= RST_CYC;
                            write_latch_flag_q  <= 1'b0;
                            read_param_bits_q   <= `FSR_PARAM_RST;
                            wrap_setting_bits_q <= `FSR_WRAP_RST;
                            s22_q               <= `FSR_S22_RST;
                            dpd_q               <= 1'b0;
                        end
                    default:
                        rst_en_q <= (op_q == `FSR_OP_RST_EN);
                endcase
            end
        end
    end

endmodule // fsr_flash_cmd
